// ==== src/sfpi_top.sv ====
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "sfpi_params.svh"

module sfpi_top (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Flash pins
    input  wire sfpi_pkg::sfpi_pins_in_t pins_in,
    output var  sfpi_pkg::sfpi_pins_out_t pins_out,
    // Device status
    output logic                        power_standby,
    output logic                        region_lock
);
    import sfpi_pkg::*;

    sfpi_state_t st;        // Registered state
    sfpi_state_t next_st;   // Next state
    logic [5:0]  s;         // Filtered pin levels
    logic [5:0]  rise;      // Filtered rising edges
    logic [5:0]  fall;      // Filtered falling edges
    logic        qe;        // Quad enable bit
    logic        protect;   // Hardware protect in force
    sfpi_lane_t  lane;      // Effective lane width
    logic [2:0]  step;      // Bits per rising edge
    logic [3:0]  mask;      // Lines driven in this width
    logic [7:0]  src;       // Byte being shifted out
    logic        setup;     // APB setup phase
    logic        commit;    // APB access completes
    logic        mapped;    // Address hits a register
    logic [31:0] rd_val;    // Read mux

    // Pins cross from the host's timing into pclk
    sfpi_sync #(
        .WIDTH (`SFPI_PIN_W)
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     (pins_in),
        .q     (s)
    );

    // Clock edges are found by comparing filtered levels; this is what
    // lets mode 0 and mode 3 idle levels both work
    assign rise = s & ~st.prev;
    assign fall = ~s & st.prev;

    // Quad enable takes the protect and pause pins away
    assign qe      = st.status_reg_two[`SFPI_SR2_QE];
    assign protect = ~qe & ~s[`SFPI_PIN_D2]
                   & ~st.status_reg_two[`SFPI_SR2_SPH]
                   & st.status_reg_one[`SFPI_SR1_SPL];

    // Quad width falls back to single unless quad enable is set
    always_comb begin
        if (st.ctrl[`SFPI_CTRL_MODE_HI:`SFPI_CTRL_MODE_LO] == SFPI_LANE_DUAL) begin
            lane = SFPI_LANE_DUAL;
            step = `SFPI_STEP_2;
            mask = `SFPI_MASK_2;
        end else if (st.ctrl[`SFPI_CTRL_MODE_HI:`SFPI_CTRL_MODE_LO] == SFPI_LANE_QUAD
                     && qe) begin
            lane = SFPI_LANE_QUAD;
            step = `SFPI_STEP_4;
            mask = `SFPI_MASK_4;
        end else begin
            lane = SFPI_LANE_SINGLE;
            step = `SFPI_STEP_1;
            mask = `SFPI_MASK_1;
        end
    end

    // A byte boundary reloads from the transmit register
    assign src = (st.pos == `SFPI_POS_START) ? st.tx_data : st.tx_shift;

    // APB phase decode
    assign setup  = psel & ~penable;
    assign commit = psel & penable & st.pready;

    // Read mux; unmapped addresses read zero and flag an error
    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0;
        case (paddr)
            `SFPI_OFF_CTRL:    rd_val[3:0] = st.ctrl;
            `SFPI_OFF_STATUS1: rd_val[7:0] = st.status_reg_one;
            `SFPI_OFF_STATUS2: rd_val[7:0] = st.status_reg_two;
            `SFPI_OFF_FLAGS: begin
                rd_val[`SFPI_FLG_SEL]    = (st.lstate == SFPI_SHIFT)
                                         | (st.lstate == SFPI_PAUSED);
                rd_val[`SFPI_FLG_ACTIVE] = ~st.standby;
                rd_val[`SFPI_FLG_PAUSED] = st.lstate == SFPI_PAUSED;
                rd_val[`SFPI_FLG_WREJ]   = st.wrej;
                rd_val[`SFPI_FLG_LOCK]   = st.lock;
                rd_val[`SFPI_FLG_ARMED]  = st.lstate != SFPI_UNARMED;
                rd_val[`SFPI_FLG_RXRDY]  = st.rx_rdy;
            end
            `SFPI_OFF_RXDATA:  rd_val[7:0] = st.rx_data;
            `SFPI_OFF_TXDATA:  rd_val[7:0] = st.tx_data;
            default:           mapped = 1'b0;
        endcase
    end

    // Next-state logic for bus, link and pins
    always_comb begin
        next_st      = st;
        next_st.prev = s;

        // Answer in the first access cycle, zero wait states
        next_st.pready  = setup;
        next_st.pslverr = setup & ~mapped;
        next_st.prdata  = setup ? rd_val : 32'h0;

        // Register writes take effect at the completing edge
        if (commit && pwrite) begin
            case (paddr)
                `SFPI_OFF_CTRL: next_st.ctrl = pwdata[3:0];
                `SFPI_OFF_STATUS1: begin
                    if (protect) begin
                        next_st.wrej = 1'b1;
                    end else begin
                        next_st.status_reg_one = pwdata[7:0];
                    end
                end
                `SFPI_OFF_STATUS2: begin
                    if (protect) begin
                        next_st.wrej = 1'b1;
                    end else begin
                        next_st.status_reg_two = pwdata[7:0];
                    end
                end
                `SFPI_OFF_FLAGS: begin
                    // Write one to clear the rejection flag
                    if (pwdata[`SFPI_FLG_WREJ]) begin
                        next_st.wrej = 1'b0;
                    end
                end
                `SFPI_OFF_TXDATA: next_st.tx_data = pwdata[7:0];
                default: ;
            endcase
        end

        // Reading the received byte clears ready; a new byte below wins
        if (commit && !pwrite && paddr == `SFPI_OFF_RXDATA) begin
            next_st.rx_rdy = 1'b0;
        end

        // Pause pin edges only count while selected and quad is off
        if (!qe && (st.lstate == SFPI_SHIFT || st.lstate == SFPI_PAUSED)) begin
            if (fall[`SFPI_PIN_D3]) begin
                next_st.pause_want = 1'b1;
            end else if (rise[`SFPI_PIN_D3]) begin
                next_st.pause_want = 1'b0;
            end
        end

        // Link state machine
        case (st.lstate)
            SFPI_UNARMED, SFPI_IDLE: begin
                // Only a falling select starts a frame, so a select held
                // low through reset stays ignored
                if (fall[`SFPI_PIN_SEL]) begin
                    next_st.lstate = SFPI_SHIFT;
                    next_st.pos    = `SFPI_POS_START;
                end
            end
            SFPI_SHIFT: begin
                if (s[`SFPI_PIN_SEL]) begin
                    next_st.lstate     = SFPI_IDLE;
                    next_st.pos        = `SFPI_POS_START;
                    next_st.pause_want = 1'b0;
                end else if (next_st.pause_want && !qe && !s[`SFPI_PIN_SCLK]) begin
                    // A pending pause waits here until the clock is low
                    next_st.lstate = SFPI_PAUSED;
                end else if (rise[`SFPI_PIN_SCLK]) begin
                    // Inputs are taken on the rising edge
                    case (lane)
                        SFPI_LANE_DUAL:
                            next_st.rx_shift = {st.rx_shift[5:0],
                                                s[1], s[0]};
                        SFPI_LANE_QUAD:
                            next_st.rx_shift = {st.rx_shift[3:0], s[3:0]};
                        default:
                            next_st.rx_shift = {st.rx_shift[6:0], s[0]};
                    endcase
                    next_st.pos = 3'(st.pos + step);
                    if (next_st.pos == `SFPI_POS_START) begin
                        next_st.rx_data = next_st.rx_shift;
                        next_st.rx_rdy  = 1'b1;
                    end
                end else if (fall[`SFPI_PIN_SCLK]) begin
                    // Outputs move only after a falling edge
                    case (lane)
                        SFPI_LANE_DUAL: begin
                            next_st.pins.data_out[1:0] = src[7:6];
                            next_st.tx_shift = {src[5:0], 2'h0};
                        end
                        SFPI_LANE_QUAD: begin
                            next_st.pins.data_out = src[7:4];
                            next_st.tx_shift = {src[3:0], 4'h0};
                        end
                        default: begin
                            next_st.pins.data_out[1] = src[7];
                            next_st.tx_shift = {src[6:0], 1'h0};
                        end
                    endcase
                end
            end
            SFPI_PAUSED: begin
                // Clock and data are ignored here; position is kept
                if (s[`SFPI_PIN_SEL]) begin
                    next_st.lstate     = SFPI_IDLE;
                    next_st.pos        = `SFPI_POS_START;
                    next_st.pause_want = 1'b0;
                end else if (qe) begin
                    next_st.lstate     = SFPI_SHIFT;
                    next_st.pause_want = 1'b0;
                end else if (!next_st.pause_want && !s[`SFPI_PIN_SCLK]) begin
                    next_st.lstate = SFPI_SHIFT;
                end
            end
            default: next_st.lstate = SFPI_UNARMED;
        endcase

        // Drive only in an active frame with transmit on; float otherwise
        if (next_st.lstate == SFPI_SHIFT && st.ctrl[`SFPI_CTRL_TXEN]) begin
            next_st.pins.data_oe_n = ~mask;
        end else begin
            next_st.pins.data_oe_n = `SFPI_MASK_4;
        end

        // Pausing never touches the busy bit, so engines run on
        next_st.standby = ~((next_st.lstate == SFPI_SHIFT)
                          | (next_st.lstate == SFPI_PAUSED)
                          | next_st.ctrl[`SFPI_CTRL_BUSY]);
        next_st.lock    = protect;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st                <= '0;
            st.ctrl           <= `SFPI_CTRL_RST;
            st.status_reg_one <= `SFPI_SR1_RST;
            st.status_reg_two <= `SFPI_SR2_RST;
            st.lstate         <= SFPI_UNARMED;
            st.pins.data_oe_n <= `SFPI_MASK_4;
            st.standby        <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign prdata        = st.prdata;
    assign pready        = st.pready;
    assign pslverr       = st.pslverr;
    assign pins_out      = st.pins;
    assign power_standby = st.standby;
    assign region_lock   = st.lock;

    // Checks run on pclk and are off during reset
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_float_idle;
        (st.lstate != SFPI_SHIFT) |-> (st.pins.data_oe_n == `SFPI_MASK_4);
    endproperty
    a_float_idle: assert property (p_float_idle)
        else $error("Output driven outside an active frame");

    property p_standby;
        st.standby == !((st.lstate == SFPI_SHIFT) || (st.lstate == SFPI_PAUSED)
                        || st.ctrl[`SFPI_CTRL_BUSY]);
    endproperty
    a_standby: assert property (p_standby)
        else $error("Standby disagrees with select and busy");

    property p_enter;
        ((st.lstate == SFPI_IDLE || st.lstate == SFPI_UNARMED)
         && fall[`SFPI_PIN_SEL]) |=> (st.lstate == SFPI_SHIFT);
    endproperty
    a_enter: assert property (p_enter)
        else $error("Select fall did not start a frame");

    property p_arm;
        (st.lstate == SFPI_UNARMED && !fall[`SFPI_PIN_SEL])
            |=> (st.lstate == SFPI_UNARMED);
    endproperty
    a_arm: assert property (p_arm)
        else $error("Device left unarmed state without select fall");

    property p_rise_pos;
        (st.lstate == SFPI_SHIFT && !s[`SFPI_PIN_SEL] && rise[`SFPI_PIN_SCLK])
            |=> (st.pos == 3'($past(st.pos) + $past(step)));
    endproperty
    a_rise_pos: assert property (p_rise_pos)
        else $error("Shift position did not advance on rising clock");

    property p_out_fall;
        !$stable(st.pins.data_out) |-> $past(fall[`SFPI_PIN_SCLK]);
    endproperty
    a_out_fall: assert property (p_out_fall)
        else $error("Output data changed without falling clock");

    property p_wrej;
        (commit && pwrite && paddr == `SFPI_OFF_STATUS1 && protect)
            |=> (st.status_reg_one == $past(st.status_reg_one)) && st.wrej;
    endproperty
    a_wrej: assert property (p_wrej)
        else $error("Protected status write was not rejected");

    property p_qe_free;
        $past(qe) |-> !st.lock;
    endproperty
    a_qe_free: assert property (p_qe_free)
        else $error("Protect lock active with quad enable set");

    property p_qe_nopause;
        qe |=> (st.lstate != SFPI_PAUSED);
    endproperty
    a_qe_nopause: assert property (p_qe_nopause)
        else $error("Paused while quad enable set");

    property p_hold_low;
        (st.lstate == SFPI_SHIFT && !qe && !s[`SFPI_PIN_SEL]
         && fall[`SFPI_PIN_D3] && !s[`SFPI_PIN_SCLK]) |=> (st.lstate == SFPI_PAUSED);
    endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("Pause not entered with clock low");

    property p_hold_high;
        (st.lstate == SFPI_SHIFT && !qe && !s[`SFPI_PIN_SEL]
         && fall[`SFPI_PIN_D3] && s[`SFPI_PIN_SCLK]) |=> (st.lstate == SFPI_SHIFT);
    endproperty
    a_hold_high: assert property (p_hold_high)
        else $error("Pause entered while clock high");

    property p_release;
        (st.lstate == SFPI_PAUSED && !qe && !s[`SFPI_PIN_SEL]
         && rise[`SFPI_PIN_D3] && !s[`SFPI_PIN_SCLK]) |=> (st.lstate == SFPI_SHIFT);
    endproperty
    a_release: assert property (p_release)
        else $error("Pause not left on release with clock low");

    property p_freeze;
        (st.lstate == SFPI_PAUSED) ##1 (st.lstate == SFPI_PAUSED)
            |-> $stable(st.pos) && (st.pins.data_oe_n == `SFPI_MASK_4);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("Position moved or output driven while paused");

    c_pause: cover property ((st.lstate == SFPI_SHIFT) ##1 (st.lstate == SFPI_PAUSED));
    c_byte: cover property ($rose(st.rx_rdy));
    c_reject: cover property ($rose(st.wrej));
    c_quad: cover property (lane == SFPI_LANE_QUAD && rise[`SFPI_PIN_SCLK]);

endmodule : sfpi_top
`default_nettype wire

// ==== include/sfpi_params.svh ====
`ifndef SFPI_PARAMS_SVH
`define SFPI_PARAMS_SVH

// Register byte offsets on the APB bus
`define SFPI_OFF_CTRL     8'h00
`define SFPI_OFF_STATUS1  8'h04
`define SFPI_OFF_STATUS2  8'h08
`define SFPI_OFF_FLAGS    8'h0C
`define SFPI_OFF_RXDATA   8'h10
`define SFPI_OFF_TXDATA   8'h14

// Control register fields
`define SFPI_CTRL_MODE_HI 1
`define SFPI_CTRL_MODE_LO 0
`define SFPI_CTRL_TXEN    2
`define SFPI_CTRL_BUSY    3
`define SFPI_CTRL_RST     4'h0

// Status register fields
`define SFPI_SR1_SPL      7
`define SFPI_SR2_SPH      0
`define SFPI_SR2_QE       1
`define SFPI_SR1_RST      8'h00
`define SFPI_SR2_RST      8'h00

// Flag register fields
`define SFPI_FLG_SEL      0
`define SFPI_FLG_ACTIVE   1
`define SFPI_FLG_PAUSED   2
`define SFPI_FLG_WREJ     3
`define SFPI_FLG_LOCK     4
`define SFPI_FLG_ARMED    5
`define SFPI_FLG_RXRDY    6

// Synchronised pin vector positions
`define SFPI_PIN_W        6
`define SFPI_PIN_SEL      5
`define SFPI_PIN_SCLK     4
`define SFPI_PIN_D3       3
`define SFPI_PIN_D2       2

// Bits taken per clock edge, and drive masks per lane mode
`define SFPI_STEP_1       3'h1
`define SFPI_STEP_2       3'h2
`define SFPI_STEP_4       3'h4
`define SFPI_MASK_1       4'h2
`define SFPI_MASK_2       4'h3
`define SFPI_MASK_4       4'hF
`define SFPI_POS_START    3'h0

`endif

// ==== include/sfpi_pkg.sv ====
`include "sfpi_params.svh"

package sfpi_pkg;

    // Lane width of the current transfer
    typedef enum logic [1:0] {
        SFPI_LANE_SINGLE = 2'h0,
        SFPI_LANE_DUAL   = 2'h1,
        SFPI_LANE_QUAD   = 2'h2
    } sfpi_lane_t;

    // Link state, Gray coded along idle, shift, pause
    typedef enum logic [1:0] {
        SFPI_IDLE    = 2'h0,
        SFPI_SHIFT   = 2'h1,
        SFPI_PAUSED  = 2'h3,
        SFPI_UNARMED = 2'h2
    } sfpi_link_t;

    // Pin levels arriving from the host
    typedef struct packed {
        logic       sel_n;
        logic       sclk;
        logic [3:0] data_line;
    } sfpi_pins_in_t;

    // Pin drive toward the host; enable low means driving
    typedef struct packed {
        logic [3:0] data_out;
        logic [3:0] data_oe_n;
    } sfpi_pins_out_t;

    // Whole state of the top module
    typedef struct packed {
        logic [3:0]     ctrl;
        logic [7:0]     status_reg_one;
        logic [7:0]     status_reg_two;
        sfpi_link_t     lstate;
        logic [2:0]     pos;
        logic [7:0]     rx_shift;
        logic [7:0]     rx_data;
        logic           rx_rdy;
        logic [7:0]     tx_data;
        logic [7:0]     tx_shift;
        logic           pause_want;
        logic           wrej;
        logic [5:0]     prev;
        sfpi_pins_out_t pins;
        logic           standby;
        logic           lock;
        logic [31:0]    prdata;
        logic           pready;
        logic           pslverr;
    } sfpi_state_t;

endpackage : sfpi_pkg

// ==== src/sfpi_sync.sv ====
`timescale 1ns/1ns
`default_nettype none

// Three-stage synchroniser; a bit only moves once stages two and three agree
module sfpi_sync #(
    parameter int WIDTH = 6
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Raw and filtered levels
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    // Local state in one record
    typedef struct packed {
        logic [WIDTH-1:0] f1;
        logic [WIDTH-1:0] f2;
        logic [WIDTH-1:0] f3;
        logic [WIDTH-1:0] q;
    } sfpi_sync_state_t;

    sfpi_sync_state_t st;      // Registered state
    sfpi_sync_state_t next_st; // Next state

    // Stage one feeds only stage two; the agree test looks at two and three
    always_comb begin
        next_st    = st;
        next_st.f1 = d;
        next_st.f2 = st.f1;
        next_st.f3 = st.f2;
        next_st.q  = (~(st.f2 ^ st.f3) & st.f3) | ((st.f2 ^ st.f3) & st.q);
    end

    // Reset to low: a select already low at power-up never shows an edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.q;

endmodule : sfpi_sync
`default_nettype wire

// ==== verif/sfpi_host.sv ====
`timescale 1ns/1ns
`default_nettype none

// Host controller model; pins move only just after pclk edges
module sfpi_host (
    // Clock and device drive
    input  wire logic                     pclk,
    input  wire sfpi_pkg::sfpi_pins_out_t pins_out,
    // Pins toward the device
    output var  sfpi_pkg::sfpi_pins_in_t  pins_in
);
    import sfpi_pkg::*;
    logic       sel_n, sclk, pmon;
    logic [3:0] hoe, hdrv, lvl, strap_n;
    logic [3:0] last = 4'h0;
    int         bad = 0;

    // Select starts low at power-up to probe arming
    initial begin
        sel_n = 1'b0;
        sclk = 1'b0;
        pmon = 1'b0;
        hoe = 4'h0;
        hdrv = 4'h0;
        strap_n = 4'hF;
    end

    // Wire level; released lines 2,3 pull up, 0,1 toggle so no stale value hides
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!pins_out.data_oe_n[i]) lvl[i] = pins_out.data_out[i];
            else if (hoe[i]) lvl[i] = hdrv[i];
            else lvl[i] = (i >= 2) ? strap_n[i] : ~last[i];
        end
    end

    // Any drive while pmon is set, inside a pause, is counted
    always @(posedge pclk) begin
        last <= lvl;
        if (pmon && pins_out.data_oe_n != 4'hF) bad <= bad + 1;
    end

    assign pins_in = {sel_n, sclk, lvl};

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    // Deselect so the next frame opens with a falling select
    task automatic park;
        sel_n <= 1'b1;
        tick(8);
    endtask : park

    // Straps: {pause, protect}, low level drives the line
    task automatic strap(input logic [1:0] v);
        strap_n <= {v, 2'b11};
        tick(8);
    endtask : strap

    // One frame of nr rises, w lines wide, optional pause after rise pk
    task automatic frame(input int w, input int nr, input logic idle, input logic [31:0] bits,
                         input int pk, input logic ph, output logic [31:0] got);
        got = 32'h0;
        sclk <= idle;
        tick(8);
        sel_n <= 1'b0;
        hoe <= (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
        tick(8);
        for (int k = 0; k < nr; k++) begin
            sclk <= 1'b0;
            hdrv <= 4'(bits[31 - k * w -: 4] >> (4 - w));
            tick(8);
            sclk <= 1'b1;
            got = {got[30:0], lvl[1]};
            tick(8);
            if (k == pk) begin
                if (ph) begin
                    strap_n[3] <= 1'b0;
                    tick(8);
                end
                sclk <= 1'b0;
                tick(8);
                strap_n[3] <= 1'b0;
                tick(8);
                pmon <= 1'b1;
                hdrv <= ~hdrv;
                sclk <= 1'b1;
                tick(8);
                sclk <= 1'b0;
                tick(8);
                pmon <= 1'b0;
                strap_n[3] <= 1'b1;
                tick(8);
            end
        end
        sclk <= idle;
        tick(8);
        sel_n <= 1'b1;
        hoe <= 4'h0;
        tick(8);
    endtask : frame
endmodule : sfpi_host

`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import sfpi_pkg::*;
    logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic           power_standby, region_lock;
    logic [7:0]     paddr, b0, b1;
    logic [31:0]    pwdata, prdata, r, got;
    sfpi_pins_in_t  pins_in;
    sfpi_pins_out_t pins_out;
    int             errors, n_compared, seed;

    sfpi_top sfpi_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins_in(pins_in), .pins_out(pins_out),
        .power_standby(power_standby), .region_lock(region_lock));
    sfpi_host sfpi_host_inst (.pclk(pclk), .pins_out(pins_out), .pins_in(pins_in));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic stop_test;
        if (errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic cmp(input string s, input logic [31:0] x, input logic [31:0] a);
        n_compared++;
        if (a !== x) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", s, x, a);
        end
    endtask : cmp

    // APB master: hold the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            errors++;
            stop_test;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        cmp(s, x, r);
    endtask : rdc

    // A hang is cut short here
    initial begin
        #900000;
        errors++;
        stop_test;
    end

    initial begin
        seed = 90854;
        errors = 0;
        n_compared = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        sfpi_host_inst.tick(12);
        apb(1'b0, 8'h0C, 32'h0);
        cmp("armed", 32'h0, {31'h0, r[5]});
        for (int a = 0; a < 12; a += 4) rdc("reset", 8'(a), 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        cmp("slverr", 32'h1, {31'h0, e});
        sfpi_host_inst.park;
        cmp("float", 32'hF, {28'h0, pins_out.data_oe_n});
        cmp("standby", 32'h1, {31'h0, power_standby});
        apb(1'b1, 8'h00, 32'h8);
        cmp("busy", 32'h0, {31'h0, power_standby});
        // Single lane in modes 0 and 3, random bytes both ways
        for (int n = 0; n < 4; n++) begin
            b0 = 8'($random(seed));
            b1 = 8'($random(seed));
            apb(1'b1, 8'h14, {24'h0, b1});
            apb(1'b1, 8'h00, 32'h4);
            fork
                sfpi_host_inst.frame(1, 16, n[0], {b0, b1, 16'h0}, -1, 1'b0, got);
                begin
                    sfpi_host_inst.tick(40);
                    cmp("active", 32'h0, {31'h0, power_standby});
                end
            join
            rdc("rx", 8'h10, {24'h0, b1});
            cmp("tx", {24'h0, b1}, {24'h0, got[7:0]});
        end
        apb(1'b1, 8'h00, 32'h1);
        sfpi_host_inst.frame(2, 4, 1'b0, {b0, 24'h0}, -1, 1'b0, got);
        rdc("rx dual", 8'h10, {24'h0, b0});
        apb(1'b1, 8'h08, 32'h2);
        apb(1'b1, 8'h00, 32'h2);
        sfpi_host_inst.frame(4, 2, 1'b0, {b1, 24'h0}, -1, 1'b0, got);
        rdc("rx quad", 8'h10, {24'h0, b1});
        // Protect pin ignored under quad enable, then honoured
        sfpi_host_inst.strap(2'b00);
        apb(1'b1, 8'h04, 32'h80);
        cmp("lock qe", 32'h0, {31'h0, region_lock});
        apb(1'b1, 8'h08, 32'h0);
        sfpi_host_inst.strap(2'b10);
        cmp("lock", 32'h1, {31'h0, region_lock});
        apb(1'b1, 8'h04, 32'h0);
        rdc("sr1 kept", 8'h04, 32'h80);
        apb(1'b0, 8'h0C, 32'h0);
        cmp("wrej", 32'h1, {31'h0, r[3]});
        apb(1'b1, 8'h0C, 32'h8);
        sfpi_host_inst.strap(2'b11);
        cmp("unlock", 32'h0, {31'h0, region_lock});
        apb(1'b1, 8'h04, 32'h0);
        rdc("sr1 free", 8'h04, 32'h0);
        // Pause pin asserted with clock low, then with clock high
        apb(1'b1, 8'h00, 32'hC);
        for (int p = 0; p < 2; p++) begin
            sfpi_host_inst.frame(1, 8, 1'b0, {b0, 24'h0}, 3, p[0], got);
            rdc("rx pause", 8'h10, {24'h0, b0});
        end
        cmp("pause float", 32'h0, 32'(sfpi_host_inst.bad));
        cmp("busy pause", 32'h0, {31'h0, power_standby});
        stop_test;
    end
endmodule : testbench

`default_nettype wire
